// ==== rtl/lja_liu.sv ====
`default_nettype none
// What this block does
// [R1] Each port instance holds its own independently configured attenuator.
// [R2] Attenuator depth selects 32 or 128 bits by a control field.
// [R3] Software picks 128 for large wander, 32 for low delay.
// [R4] Two path bits place attenuator in receive or transmit path, or off.
// [R5] Master clock is 1.544 or 2.048 MHz, or up to 8x either; the smoother here assumes a fixed 20 MHz aclk (LJA_ACLK_HZ).
// [R6] A smoothed clock from the selected source reads the attenuator FIFO.
// [R7] A gapped or bursty transmit clock is tolerated in transmit placement.
// [R8] Limit-trip flag latches beyond 120 UI (128 deep) or 28 UI (32 deep).
// [R9] Smoothing corner is 3.75 Hz for T1/J1, 0.6 Hz for E1.
// [R10] Analog loopback feeds transmit output to receiver, ignoring line input.
// [R11] Local loopback sends transmit data to receive framer and line.
// [R12] Remote loopback 1 returns line data to transmitter, bypassing attenuator.
// [R13] Remote loopback 2 returns line data to transmitter through attenuator.
// [R14] Dual loopback combines local and remote 1; attenuator optional.
// [R15] Only one loopback at a time, except the dual combination.

// ****************
// Attenuator FIFO
// ****************
module lja_fifo #(
  parameter int WIDTH = 4,
  parameter int DEPTH = 32
) (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Fill side
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  // Drain side
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data,
  // Fill level
  output logic [$clog2(DEPTH):0] level
);
  localparam int AW = $clog2(DEPTH);
  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [AW-1:0] wp;
    logic [AW-1:0] rp;
    logic [AW:0] cnt;
  } lja_fifo_st_t;
  lja_fifo_st_t st_r, st_nxt;
  logic push, pop;

  if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0) begin : g_chk
    $error("lja_fifo: DEPTH must be a power of two");
  end

  assign in_ready = st_r.cnt != (AW + 1)'(DEPTH);
  assign out_valid = st_r.cnt != '0;
  assign out_data = st_r.mem[st_r.rp];
  assign level = st_r.cnt;
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;

  always_comb begin
    st_nxt = st_r;
    if (push) begin
      st_nxt.mem[st_r.wp] = in_data;
      st_nxt.wp = st_r.wp + 1'b1;
    end
    if (pop) begin
      st_nxt.rp = st_r.rp + 1'b1;
    end
    st_nxt.cnt = st_r.cnt + (AW + 1)'(push) - (AW + 1)'(pop);
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end
endmodule

// ****************
// Line interface port
// ****************
module lja_liu
  import lja_pkg::*;
#(
  parameter int FIFO_DEPTH = 32
) (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // AXI4-Lite slave
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Framer side
  input wire logic transmit_clock_input,
  input wire logic transmit_serial_data,
  output logic receive_clock_output,
  output logic receive_serial_data,
  // Line side, recovered and to transmitter
  input wire logic rx_recovered_clock,
  input wire logic rx_recovered_data,
  output logic tx_line_clock,
  output logic tx_line_data
);
  import lja_pkg::*;
  localparam int LW = $clog2(FIFO_DEPTH) + 1;
  localparam int BPW = LJA_BITS_PER_WORD;
  localparam logic [LW-1:0] CAP_LONG = LW'(LJA_DEPTH_LONG / BPW);
  localparam logic [LW-1:0] CAP_SHORT = LW'(LJA_DEPTH_SHORT / BPW);
  localparam logic [8:0] HALF_LONG = 9'(LJA_DEPTH_LONG / 2);
  localparam logic [8:0] HALF_SHORT = 9'(LJA_DEPTH_SHORT / 2);
  localparam logic [8:0] LIM_LONG = 9'(LJA_LIMIT_LONG_UI / 2);
  localparam logic [8:0] LIM_SHORT = 9'(LJA_LIMIT_SHORT_UI / 2);

  if (FIFO_DEPTH * BPW != LJA_DEPTH_LONG) begin : g_chk
    $error("lja_liu: FIFO must hold exactly the long depth");
  end

  typedef struct packed {
    logic depth_long;
    logic [1:0] path;
    logic e1;
    logic [3:0] mnt;
    logic trip;
    logic [2:0] sy_tc, sy_td, sy_rc, sy_rd;
    logic tc_lvl, rc_lvl;
    logic [3:0] pk_sh;
    logic [2:0] pk_cnt;
    logic pk_valid;
    logic [3:0] pk_word;
    logic [3:0] up_sh;
    logic [2:0] up_cnt;
    logic [LJA_NCO_W-1:0] nco;
    logic ja_bit;
    logic drain_on;
    logic line_clk, line_dat, line_stb, fr_clk, fr_dat;
    logic aw_got, w_got, w_lo;
    logic [7:0] awaddr;
    logic [31:0] wdata;
    logic awready, wready, bvalid, arready, rvalid;
    logic [1:0] bresp, rresp;
    logic [31:0] rdata;
  } lja_state_t;

  lja_state_t st_r, st_nxt;
  logic fifo_in_ready, fifo_out_valid, fifo_out_ready, fifo_in_valid;
  logic [3:0] fifo_out_data;
  logic [LW-1:0] fifo_level;
  logic [LW-1:0] cap;
  logic [8:0] occ, half, lim;
  logic analog, local_lb, rem1, rem2, ja_line, ja_fr, tc_edge, rc_edge, nco_carry;
  lja_bit_t tx_src, rx_eff, line_src, fr_src, ja_in;
  logic [31:0] inc, adj;
  logic [LJA_NCO_W:0] nco_sum;
  logic trip_evt, ctrl_wr, fifo_srst_n;

  function automatic logic mnt_legal(input logic [3:0] m);
    logic [3:0] dual;
    dual = '0;
    dual[LJA_MNT_LOCAL] = 1'b1;
    dual[LJA_MNT_REM1] = 1'b1;
    return $onehot0(m) || (m == dual);
  endfunction

  lja_fifo #(.WIDTH(BPW), .DEPTH(FIFO_DEPTH)) u_fifo (
    .aclk(aclk),
    .aresetn(fifo_srst_n),
    .in_valid(fifo_in_valid),
    .in_ready(fifo_in_ready),
    .in_data(st_r.pk_word),
    .out_valid(fifo_out_valid),
    .out_ready(fifo_out_ready),
    .out_data(fifo_out_data),
    .level(fifo_level)
  );

  // ****************
  // Routing and smoother
  // ****************
  assign analog = st_r.mnt[LJA_MNT_ANALOG];
  assign local_lb = st_r.mnt[LJA_MNT_LOCAL];
  assign rem1 = st_r.mnt[LJA_MNT_REM1];
  assign rem2 = st_r.mnt[LJA_MNT_REM2];
  // Edges only; a gapped clock just yields fewer strobes
  assign tc_edge = st_r.sy_tc[1] == st_r.sy_tc[2] && st_r.sy_tc[2] && !st_r.tc_lvl; // R7
  assign rc_edge = st_r.sy_rc[1] == st_r.sy_rc[2] && st_r.sy_rc[2] && !st_r.rc_lvl;
  assign tx_src = '{clk: st_r.tc_lvl, stb: tc_edge, dat: st_r.sy_td[2]};
  assign ja_line = rem2 || (st_r.path == LJA_PATH_TX && !rem1); // R4 R13
  assign ja_fr = !ja_line && st_r.path == LJA_PATH_RX; // R4 R14
  assign cap = st_r.depth_long ? CAP_LONG : CAP_SHORT; // R2
  assign half = st_r.depth_long ? HALF_LONG : HALF_SHORT;
  assign lim = st_r.depth_long ? LIM_LONG : LIM_SHORT; // R8
  assign occ = 9'({fifo_level, 2'b00}) + 9'(st_r.pk_cnt) + 9'({st_r.pk_valid, 2'b00})
    + 9'(st_r.up_cnt);
  assign fifo_in_valid = st_r.pk_valid && fifo_level < cap; // R2
  // Read rate tracks fill error; gain sets the loop corner
  assign adj = 32'(signed'({23'h0, occ}) - signed'({23'h0, half}));
  assign inc = (st_r.e1 ? LJA_INC_E1 : LJA_INC_T1)
    + (st_r.e1 ? (adj <<< LJA_GAIN_E1) : (adj <<< LJA_GAIN_T1)); // R6 R9
  assign nco_sum = {1'b0, st_r.nco} + (LJA_NCO_W + 1)'(inc);
  assign nco_carry = nco_sum[LJA_NCO_W];
  assign fifo_out_ready = nco_carry && st_r.up_cnt == 3'h0 && st_r.drain_on; // R6
  assign ctrl_wr = st_r.aw_got && st_r.w_got && !st_r.bvalid && st_r.w_lo
    && st_r.awaddr == LJA_OFF_CTRL;
  // New depth or path starts empty, so the fill never exceeds a shrunk depth
  assign fifo_srst_n = aresetn && !ctrl_wr; // R2

  always_comb begin
    // Receive line ignored during analog loopback
    rx_eff = '{clk: st_r.rc_lvl, stb: rc_edge, dat: st_r.sy_rd[2]};
    if (analog) begin
      rx_eff = '{clk: st_r.line_clk, stb: st_r.line_stb, dat: st_r.line_dat}; // R10
    end
    line_src = (rem1 || rem2) ? rx_eff : tx_src; // R12 R13 R14
    fr_src = local_lb ? tx_src : rx_eff; // R11 R14
    ja_in = ja_line ? line_src : fr_src;
  end

  always_comb begin
    st_nxt = st_r;
    trip_evt = 1'b0;
    // Three-stage pin synchronisers
    st_nxt.sy_tc = {st_r.sy_tc[1:0], transmit_clock_input};
    st_nxt.sy_td = {st_r.sy_td[1:0], transmit_serial_data};
    st_nxt.sy_rc = {st_r.sy_rc[1:0], rx_recovered_clock};
    st_nxt.sy_rd = {st_r.sy_rd[1:0], rx_recovered_data};
    if (st_r.sy_tc[1] == st_r.sy_tc[2]) begin
      st_nxt.tc_lvl = st_r.sy_tc[2];
    end
    if (st_r.sy_rc[1] == st_r.sy_rc[2]) begin
      st_nxt.rc_lvl = st_r.sy_rc[2];
    end
    // Packer fills the FIFO; a full buffer drops the bit and trips
    if (fifo_in_valid && fifo_in_ready) begin
      st_nxt.pk_valid = 1'b0;
    end
    if (ja_in.stb && (ja_line || ja_fr)) begin
      if (st_r.pk_cnt == 3'(BPW - 1) && st_nxt.pk_valid) begin
        trip_evt = 1'b1; // R8
      end else if (st_r.pk_cnt == 3'(BPW - 1)) begin
        st_nxt.pk_word = {ja_in.dat, st_r.pk_sh[3:1]};
        st_nxt.pk_valid = 1'b1;
        st_nxt.pk_cnt = 3'h0;
      end else begin
        st_nxt.pk_sh = {ja_in.dat, st_r.pk_sh[3:1]};
        st_nxt.pk_cnt = st_r.pk_cnt + 3'h1;
      end
      // Limit applies once centred; the start-up fill is not jitter
      if (st_r.drain_on && (occ > half + lim || occ + lim < half)) begin
        trip_evt = 1'b1; // R8
      end
    end
    // Smoothed clock drains one bit per carry
    st_nxt.nco = nco_sum[LJA_NCO_W-1:0]; // R6
    if (nco_carry) begin
      if (st_r.up_cnt != 3'h0) begin
        st_nxt.ja_bit = st_r.up_sh[0];
        st_nxt.up_sh = {1'b0, st_r.up_sh[3:1]};
        st_nxt.up_cnt = st_r.up_cnt - 3'h1;
      end else if (fifo_out_valid && st_r.drain_on) begin
        st_nxt.ja_bit = fifo_out_data[0];
        st_nxt.up_sh = {1'b0, fifo_out_data[3:1]};
        st_nxt.up_cnt = 3'(BPW - 1);
      end else if ((ja_line || ja_fr) && st_r.drain_on) begin
        // Underflow holds the last bit and refills to half before reading on
        trip_evt = 1'b1; // R8
        st_nxt.drain_on = 1'b0;
      end
    end
    // Slow loop cannot centre itself, so reading waits for half depth
    if (!st_r.drain_on && occ >= half) begin
      st_nxt.drain_on = 1'b1; // R6
    end
    if (trip_evt) begin
      st_nxt.trip = 1'b1; // R8
    end
    // Output stages
    st_nxt.line_stb = ja_line ? nco_carry : line_src.stb;
    st_nxt.line_clk = ja_line ? !nco_sum[LJA_NCO_W-1] : line_src.clk;
    if (ja_line && nco_carry) begin
      st_nxt.line_dat = st_nxt.ja_bit; // R13
    end else if (!ja_line && line_src.stb) begin
      st_nxt.line_dat = line_src.dat; // R11 R12
    end
    st_nxt.fr_clk = ja_fr ? !nco_sum[LJA_NCO_W-1] : fr_src.clk;
    if (ja_fr && nco_carry) begin
      st_nxt.fr_dat = st_nxt.ja_bit;
    end else if (!ja_fr && fr_src.stb) begin
      st_nxt.fr_dat = fr_src.dat; // R10 R11
    end
    // AXI4-Lite write
    if (st_r.bvalid && s_axi_bready) begin
      st_nxt.bvalid = 1'b0;
    end
    if (s_axi_awvalid && st_r.awready) begin
      st_nxt.aw_got = 1'b1;
      st_nxt.awaddr = s_axi_awaddr;
    end
    if (s_axi_wvalid && st_r.wready) begin
      st_nxt.w_got = 1'b1;
      st_nxt.wdata = s_axi_wdata;
      st_nxt.w_lo = s_axi_wstrb[0];
    end
    if (st_r.aw_got && st_r.w_got && !st_r.bvalid) begin
      st_nxt.aw_got = 1'b0;
      st_nxt.w_got = 1'b0;
      st_nxt.bvalid = 1'b1;
      st_nxt.bresp = LJA_RESP_OKAY;
      case (st_r.awaddr)
        LJA_OFF_CTRL: begin
          if (st_r.w_lo) begin
            st_nxt.depth_long = st_r.wdata[LJA_CTRL_DEPTH]; // R1 R2
            st_nxt.path = st_r.wdata[LJA_CTRL_PATH_HI:LJA_CTRL_PATH_LO]; // R4
            st_nxt.e1 = st_r.wdata[LJA_CTRL_E1]; // R9
            st_nxt.drain_on = 1'b0;
          end
        end
        LJA_OFF_MAINT: begin
          // Illegal combinations are dropped, old mode kept
          if (st_r.w_lo && mnt_legal(st_r.wdata[3:0])) begin
            st_nxt.mnt = st_r.wdata[3:0]; // R15
          end
        end
        LJA_OFF_LSTAT: begin
          // Clear loses to a trip in the same cycle
          if (st_r.w_lo && st_r.wdata[LJA_LSTAT_TRIP] && !trip_evt) begin
            st_nxt.trip = 1'b0;
          end
        end
        LJA_OFF_LEVEL: begin
          st_nxt.bresp = LJA_RESP_OKAY;
        end
        default: begin
          st_nxt.bresp = LJA_RESP_SLVERR;
        end
      endcase
    end
    st_nxt.awready = !st_nxt.aw_got && !st_nxt.bvalid;
    st_nxt.wready = !st_nxt.w_got && !st_nxt.bvalid;
    // AXI4-Lite read
    if (st_r.rvalid && s_axi_rready) begin
      st_nxt.rvalid = 1'b0;
    end
    if (s_axi_arvalid && st_r.arready) begin
      st_nxt.rvalid = 1'b1;
      st_nxt.rresp = LJA_RESP_OKAY;
      st_nxt.rdata = '0;
      case (s_axi_araddr)
        LJA_OFF_CTRL: begin
          st_nxt.rdata[LJA_CTRL_DEPTH] = st_r.depth_long;
          st_nxt.rdata[LJA_CTRL_PATH_HI:LJA_CTRL_PATH_LO] = st_r.path;
          st_nxt.rdata[LJA_CTRL_E1] = st_r.e1;
        end
        LJA_OFF_MAINT: begin
          st_nxt.rdata[3:0] = st_r.mnt;
        end
        LJA_OFF_LSTAT: begin
          st_nxt.rdata[LJA_LSTAT_TRIP] = st_r.trip;
        end
        LJA_OFF_LEVEL: begin
          st_nxt.rdata[8:0] = occ;
        end
        default: begin
          st_nxt.rresp = LJA_RESP_SLVERR;
        end
      endcase
    end
    st_nxt.arready = !st_nxt.rvalid;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign s_axi_awready = st_r.awready;
  assign s_axi_wready = st_r.wready;
  assign s_axi_bvalid = st_r.bvalid;
  assign s_axi_bresp = st_r.bresp;
  assign s_axi_arready = st_r.arready;
  assign s_axi_rvalid = st_r.rvalid;
  assign s_axi_rresp = st_r.rresp;
  assign s_axi_rdata = st_r.rdata;
  assign receive_clock_output = st_r.fr_clk;
  assign receive_serial_data = st_r.fr_dat;
  assign tx_line_clock = st_r.line_clk;
  assign tx_line_data = st_r.line_dat;

  // ****************
  // Checks
  // ****************
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  a_loop_mode_legal: assert property (mnt_legal(st_r.mnt)) // R15
    else $error("illegal loopback combination");
  a_fifo_under_cap: assert property (fifo_level <= cap) // R2
    else $error("attenuator exceeds selected depth");
  a_trip_on_overflow: assert property ((ja_line || ja_fr) && ja_in.stb
    && st_r.pk_valid && !fifo_in_ready && st_r.pk_cnt == 3'(BPW - 1) |=> st_r.trip) // R8
    else $error("overflow did not trip");
  a_rem1_bypass: assert property (rem1 && !ja_line && rx_eff.stb
    |=> tx_line_data == $past(rx_eff.dat)) // R12
    else $error("remote loopback 1 data wrong");
  a_local_to_framer: assert property (local_lb && !ja_fr && tc_edge
    |=> receive_serial_data == $past(st_r.sy_td[2])) // R11
    else $error("local loopback data wrong");
  a_analog_return: assert property (analog && !ja_fr && st_r.line_stb
    |=> receive_serial_data == $past(tx_line_data)) // R10
    else $error("analog loopback data wrong");
  a_rem2_smoothed: assert property (rem2 && nco_carry
    |=> tx_line_data == st_r.ja_bit && tx_line_clock) // R13
    else $error("remote loopback 2 bypassed smoother");
  a_path_off_direct: assert property (st_r.mnt == 4'h0 && !st_r.path[1] && tc_edge
    |=> tx_line_data == $past(st_r.sy_td[2])) // R4
    else $error("transmit path not direct");
  c_dual_loop: cover property (local_lb && rem1 && tc_edge);
  c_rem2_run: cover property (rem2 && fifo_out_ready && fifo_out_valid);
  c_trip_set: cover property (!st_r.trip ##1 st_r.trip);
  c_centred: cover property (!st_r.drain_on ##1 st_r.drain_on);
endmodule
`default_nettype wire

// ==== rtl/lja_pkg.sv ====
`default_nettype none
package lja_pkg;
  // ****************
  // Register map
  // ****************
  localparam logic [7:0] LJA_OFF_CTRL = 8'h00;
  localparam logic [7:0] LJA_OFF_MAINT = 8'h04;
  localparam logic [7:0] LJA_OFF_LSTAT = 8'h08;
  localparam logic [7:0] LJA_OFF_LEVEL = 8'h0c;
  localparam int LJA_CTRL_DEPTH = 0;
  localparam int LJA_CTRL_PATH_LO = 1;
  localparam int LJA_CTRL_PATH_HI = 2;
  localparam int LJA_CTRL_E1 = 3;
  localparam int LJA_MNT_ANALOG = 0;
  localparam int LJA_MNT_LOCAL = 1;
  localparam int LJA_MNT_REM1 = 2;
  localparam int LJA_MNT_REM2 = 3;
  localparam int LJA_LSTAT_TRIP = 3;
  localparam logic [1:0] LJA_RESP_OKAY = 2'h0;
  localparam logic [1:0] LJA_RESP_SLVERR = 2'h2;
  typedef enum logic [1:0] {
    LJA_PATH_OFF = 2'h0,
    LJA_PATH_RX = 2'h1,
    LJA_PATH_TX = 2'h2,
    LJA_PATH_OFF2 = 2'h3
  } lja_path_t;
  // ****************
  // Smoother figures
  // ****************
  localparam int LJA_DEPTH_SHORT = 32;
  localparam int LJA_DEPTH_LONG = 128;
  localparam int LJA_LIMIT_SHORT_UI = 28;
  localparam int LJA_LIMIT_LONG_UI = 120;
  localparam int LJA_BITS_PER_WORD = 4;
  localparam longint LJA_ACLK_HZ = 20000000;
  localparam longint LJA_T1_HZ = 1544000;
  localparam longint LJA_E1_HZ = 2048000;
  localparam int LJA_NCO_W = 24;
  localparam logic [31:0] LJA_INC_T1 = 32'((LJA_T1_HZ << LJA_NCO_W) / LJA_ACLK_HZ);
  localparam logic [31:0] LJA_INC_E1 = 32'((LJA_E1_HZ << LJA_NCO_W) / LJA_ACLK_HZ);
  localparam int LJA_CORNER_T1_MHZ = 3750;
  localparam int LJA_CORNER_E1_MHZ = 600;
  // Loop gain shifts; the lower E1 corner takes the weaker gain
  localparam int LJA_GAIN_T1 = 6;
  localparam int LJA_GAIN_E1 = 3;
  // ****************
  // Carriers
  // ****************
  typedef struct packed {
    logic clk;
    logic stb;
    logic dat;
  } lja_bit_t;
endpackage
`default_nettype wire

// ==== testbench/lja_line_model.sv ====
`default_nettype none
// ****************
// Serial source: framer pins or recovered line
// ****************
module lja_line_model #(
  parameter int PER = 13
) (
  // Clock
  input wire logic aclk,
  // Control
  input wire logic run,
  input wire logic gapped,
  input wire logic level,
  // Serial pins
  output logic line_clk,
  output logic line_dat
);
  timeunit 1ns;
  timeprecision 1ns;
  int ph;
  int nb;
  int pl;
  initial begin
    line_clk = 1'b0;
    line_dat = 1'b0;
    ph = 0;
    nb = 0;
  end
  // Bursts run faster, so the average rate stays near the smooth one
  assign pl = gapped ? 10 : PER;
  always @(posedge aclk) begin
    if (!run) begin
      // Clock stands still; a stale data level must not pass for data
      line_clk <= 1'b0;
      line_dat <= ~line_dat;
      ph <= 0;
      nb <= 0;
    end else if (gapped && nb == 8) begin
      // Gap of several bit times between bursts of eight clocks
      line_clk <= 1'b0;
      ph <= (ph == 33) ? 0 : ph + 1;
      if (ph == 33) begin
        nb <= 0;
      end
    end else begin
      ph <= (ph >= pl - 1) ? 0 : ph + 1;
      line_clk <= (ph < pl / 2);
      // Data moves on the falling clock, far from the sampling rise
      if (ph == pl / 2) begin
        line_dat <= level;
        nb <= gapped ? nb + 1 : 0;
      end
    end
  end
endmodule
`default_nettype wire

// ==== testbench/lja_liu_tb.sv ====
`default_nettype none
module lja_liu_tb;
  timeunit 1ns;
  timeprecision 1ns;
  import lja_pkg::*;
  // ****************
  // Stimulus and wires
  // ****************
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [7:0] aw_a = 8'h00;
  logic [7:0] ar_a = 8'h00;
  logic [31:0] w_d = 32'h0;
  logic [3:0] w_s = 4'h0;
  logic aw_v = 1'b0, w_v = 1'b0, b_r = 1'b0, ar_v = 1'b0, r_rd = 1'b0;
  logic aw_r, w_r, b_v, ar_r, r_v;
  logic [1:0] b_rsp, r_rsp;
  logic [31:0] r_d;
  logic t_run = 1'b0, t_gap = 1'b0, t_lvl = 1'b0, x_run = 1'b0, x_lvl = 1'b0;
  logic tclk, tdat, rclk_o, rdat_o, xclk, xdat, txclk_o, txdat_o;
  int n_errors = 0;
  int samples_checked = 0;
  int cycles = 0;
  always #25 aclk = ~aclk;

  lja_liu #(.FIFO_DEPTH(32)) u_dut (
    .aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(aw_a), .s_axi_awvalid(aw_v), .s_axi_awready(aw_r),
    .s_axi_wdata(w_d), .s_axi_wstrb(w_s), .s_axi_wvalid(w_v), .s_axi_wready(w_r),
    .s_axi_bresp(b_rsp), .s_axi_bvalid(b_v), .s_axi_bready(b_r),
    .s_axi_araddr(ar_a), .s_axi_arvalid(ar_v), .s_axi_arready(ar_r),
    .s_axi_rdata(r_d), .s_axi_rresp(r_rsp), .s_axi_rvalid(r_v), .s_axi_rready(r_rd),
    .transmit_clock_input(tclk), .transmit_serial_data(tdat),
    .receive_clock_output(rclk_o), .receive_serial_data(rdat_o),
    .rx_recovered_clock(xclk), .rx_recovered_data(xdat),
    .tx_line_clock(txclk_o), .tx_line_data(txdat_o)
  );
  lja_line_model #(.PER(13)) u_tx_side (.aclk(aclk), .run(t_run), .gapped(t_gap),
    .level(t_lvl), .line_clk(tclk), .line_dat(tdat));
  lja_line_model #(.PER(13)) u_rx_side (.aclk(aclk), .run(x_run), .gapped(1'b0),
    .level(x_lvl), .line_clk(xclk), .line_dat(xdat));

  // ****************
  // Bus cycles and compares
  // ****************
  task automatic check(input string nm, input logic [31:0] exp, input logic [31:0] got);
    samples_checked++;
    if (got !== exp) begin
      n_errors++;
      $display("mismatch %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s,
                    output logic [1:0] rsp);
    @(posedge aclk);
    aw_a <= a;
    w_d <= d;
    w_s <= s;
    aw_v <= 1'b1;
    w_v <= 1'b1;
    b_r <= 1'b1;
    forever begin
      @(posedge aclk);
      if (aw_v && aw_r) aw_v <= 1'b0;
      if (w_v && w_r) w_v <= 1'b0;
      if (b_v) begin
        rsp = b_rsp;
        b_r <= 1'b0;
        break;
      end
    end
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] rsp);
    @(posedge aclk);
    ar_a <= a;
    ar_v <= 1'b1;
    r_rd <= 1'b1;
    forever begin
      @(posedge aclk);
      if (ar_v && ar_r) ar_v <= 1'b0;
      if (r_v) begin
        d = r_d;
        rsp = r_rsp;
        r_rd <= 1'b0;
        break;
      end
    end
  endtask
  task automatic wreg(input logic [7:0] a, input logic [31:0] d);
    logic [1:0] r;
    wr(a, d, 4'hf, r);
    check("bresp", {30'h0, LJA_RESP_OKAY}, {30'h0, r});
  endtask
  task automatic rchk(input string nm, input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] d;
    logic [1:0] r;
    rd(a, d, r);
    check(nm, exp, d);
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge aclk);
  endtask
  task automatic print_verdict();
    $display("checks %0d errors %0d", samples_checked, n_errors);
    if (n_errors == 0 && samples_checked > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  // Cut a hang short well beyond the expected run length
  always @(posedge aclk) begin
    cycles++;
    if (cycles == 40000) begin
      n_errors++;
      print_verdict();
    end
  end

  // ****************
  // Main sequence
  // ****************
  logic [31:0] good[5] = '{32'h1, 32'h2, 32'h4, 32'h8, 32'h6};
  logic [31:0] bad[6] = '{32'h3, 32'h5, 32'h9, 32'hc, 32'he, 32'hf};
  // Loopback table: mode, receive output from framer side, receive checked, line from framer
  logic [31:0] lb[5] = '{32'h0, 32'h1, 32'h2, 32'h4, 32'h6};
  logic rx_t[5] = '{1'b0, 1'b1, 1'b1, 1'b0, 1'b1};
  logic rx_c[5] = '{1'b1, 1'b1, 1'b1, 1'b1, 1'b1};
  logic tx_t[5] = '{1'b1, 1'b1, 1'b1, 1'b0, 1'b0};
  logic [31:0] d;
  logic [1:0] r;
  initial begin
    cyc(12);
    aresetn <= 1'b1;
    cyc(2);
    rchk("ctrl_reset", LJA_OFF_CTRL, 32'h0);
    rchk("maint_reset", LJA_OFF_MAINT, 32'h0);
    rchk("lstat_reset", LJA_OFF_LSTAT, 32'h0);
    rd(8'h10, d, r);
    check("rresp_unmapped", {30'h0, LJA_RESP_SLVERR}, {30'h0, r});
    check("rdata_unmapped", 32'h0, d);
    wr(8'h14, 32'hf, 4'hf, r);
    check("bresp_unmapped", {30'h0, LJA_RESP_SLVERR}, {30'h0, r});
    wreg(LJA_OFF_CTRL, 32'hf);
    rchk("ctrl_fields", LJA_OFF_CTRL, 32'hf);
    wr(LJA_OFF_CTRL, 32'h0, 4'he, r);
    rchk("ctrl_strobe", LJA_OFF_CTRL, 32'hf);
    wreg(LJA_OFF_CTRL, 32'h0);
    foreach (good[i]) begin
      wreg(LJA_OFF_MAINT, good[i]);
      rchk("maint_legal", LJA_OFF_MAINT, good[i]);
    end
    wreg(LJA_OFF_MAINT, 32'h0);
    foreach (bad[i]) begin
      wreg(LJA_OFF_MAINT, bad[i]);
      rchk("maint_illegal", LJA_OFF_MAINT, 32'h0);
    end
    t_run <= 1'b1;
    x_run <= 1'b1;
    // Opposite levels on the two sources show which one reaches each output
    foreach (lb[i]) begin
      wreg(LJA_OFF_MAINT, lb[i]);
      for (int k = 0; k < 2; k++) begin
        t_lvl <= k[0];
        x_lvl <= ~k[0];
        cyc(150);
        if (rx_c[i]) check("rx_out", {31'h0, rx_t[i] ? k[0] : ~k[0]}, {31'h0, rdat_o});
        check("line_out", {31'h0, tx_t[i] ? k[0] : ~k[0]}, {31'h0, txdat_o});
      end
    end
    wreg(LJA_OFF_MAINT, 32'h8);
    x_lvl <= 1'b1;
    t_lvl <= 1'b0;
    cyc(2000);
    check("remote2_hi", 32'h1, {31'h0, txdat_o});
    x_lvl <= 1'b0;
    t_lvl <= 1'b1;
    cyc(1500);
    check("remote2_lo", 32'h0, {31'h0, txdat_o});
    wreg(LJA_OFF_MAINT, 32'h0);
    // Short buffer first for low delay, then long for wander
    wreg(LJA_OFF_CTRL, 32'h2);
    x_lvl <= 1'b1;
    cyc(2500);
    check("smooth_rx", 32'h1, {31'h0, rdat_o});
    rd(LJA_OFF_LEVEL, d, r);
    check("level_short", 32'h1, {31'h0, d[8:0] > 9'd2 && d[8:0] <= 9'd32});
    wreg(LJA_OFF_CTRL, 32'h3);
    cyc(5000);
    rd(LJA_OFF_LEVEL, d, r);
    check("level_long", 32'h1, {31'h0, d[8:0] > 9'd32});
    wreg(LJA_OFF_LSTAT, 32'h8);
    rchk("trip_idle", LJA_OFF_LSTAT, 32'h0);
    x_run <= 1'b0;
    cyc(1000);
    rchk("trip_set", LJA_OFF_LSTAT, 32'h8);
    x_run <= 1'b1;
    cyc(5000);
    wreg(LJA_OFF_LSTAT, 32'h8);
    rchk("trip_clear", LJA_OFF_LSTAT, 32'h0);
    wreg(LJA_OFF_CTRL, 32'h4);
    t_gap <= 1'b1;
    t_lvl <= 1'b1;
    cyc(3000);
    check("smooth_tx", 32'h1, {31'h0, txdat_o});
    wreg(LJA_OFF_LSTAT, 32'h8);
    cyc(1000);
    rchk("trip_gapped", LJA_OFF_LSTAT, 32'h0);
    print_verdict();
  end
endmodule
`default_nettype wire
